//--- src/serial_flash_pin_interface.sv
// serial flash pin interface: select, lanes, write protect and register bus
// How it works
// - chip select high: deselected, every output lane floats.
// - deselected: frame logic held idle in standby until selected again.
// - chip select low selects; instructions, read data and write data accepted.
// - after power-up no instruction accepted before a select falling edge.
// - anything on the lanes while chip select is high is discarded.
// - single lane: inputs captured from lane 0 on rising clock edges.
// - single lane: read data driven on lane 1 from falling edges.
// - quad: lanes bidirectional, in on rising, out on falling; dual: lanes 0 and 1 only out, on falling.
// - quad: write-protect and pause pins become lanes 2 and 3.
// - write-disable set and protect low: protected status bits refuse writes.
// - write-disable clear: status writes allowed whatever the protect pin.
// - quad enable set disables the write-protect function of lane 2.
// - quad enable clear: lane 3 is pause, or restart when selected so.
// - works in clock modes 0 and 3; rise captures, fall drives.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_pin_interface (
    // system clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // register bus
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // serial link
    input  wire logic        sck,
    input  wire logic        chip_select_n,
    input  wire logic [3:0]  data_lane_in,
    output logic      [3:0]  data_lane_out,
    output logic      [3:0]  data_lane_oe,
    // power state
    output logic             standby
);
    lane_if lif ();

    // ------------------------------------------------------------
    // system-domain state
    // ------------------------------------------------------------
    logic [7:0]  status;
    logic        hrs;
    logic        armed;
    logic [9:0]  snap;
    logic        prev_tog;
    logic [15:0] rejects;
    logic        restart_seen;
    logic [7:0]  next_status;
    logic        next_hrs;
    logic        next_armed;
    logic [9:0]  next_snap;
    logic [15:0] next_rejects;
    logic        next_restart_seen;
    logic        next_wait;
    logic [31:0] next_rdata;
    logic [2:0]  pins_sync;
    logic        tog_sync;

    // ------------------------------------------------------------
    // link-domain state
    // ------------------------------------------------------------
    flash_pin_pkg::phase_t     phase;
    flash_pin_pkg::phase_t     next_phase;
    flash_pin_pkg::lane_mode_t mode;
    flash_pin_pkg::lane_mode_t next_mode;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic [7:0] sr;
    logic [7:0] next_sr;
    logic [7:0] wr_word;
    logic [7:0] next_wr_word;
    logic       wr_tog;
    logic       next_wr_tog;
    logic       snap_armed;
    logic       snap_hrs;
    logic       snap_qe;
    logic       restart;

    // ------------------------------------------------------------
    // pin function selection
    // ------------------------------------------------------------
    // snapshot only moves while deselected, so it is steady during a frame
    assign snap_armed = snap[9];
    assign snap_hrs   = snap[8];
    assign snap_qe    = snap[flash_pin_pkg::QE_BIT];
    assign restart    = !snap_qe && snap_hrs && !data_lane_in[3];
    // pause only acts while selected, since the engine is cleared otherwise
    assign lif.paused  = !snap_qe && !snap_hrs && !data_lane_in[3];
    // a pin-driven clear: glitches on these pins abort the frame, as intended
    assign lif.clear   = chip_select_n || restart;
    assign lif.rd_mode = mode;
    assign lif.rd_byte = snap[7:0];

    // ------------------------------------------------------------
    // frame engine on the link clock
    // ------------------------------------------------------------
    // decode and shift; a paused frame keeps its place
    always_comb begin
        next_phase   = phase;
        next_mode    = mode;
        next_cnt     = cnt;
        next_sr      = sr;
        next_wr_word = wr_word;
        next_wr_tog  = wr_tog;
        if (!lif.paused) begin
            unique case (phase)
                flash_pin_pkg::PH_CMD: begin
                    next_sr  = {sr[6:0], data_lane_in[0]};
                    next_cnt = cnt + 3'h1;
                    if (cnt == flash_pin_pkg::LAST_SINGLE_BEAT) begin
                        next_cnt   = 3'h0;
                        next_phase = flash_pin_pkg::PH_IGNORE;
                        if (snap_armed) begin
                            unique case (next_sr)
                                flash_pin_pkg::CMD_READ_STATUS: begin
                                    next_phase = flash_pin_pkg::PH_RD;
                                    next_mode  = flash_pin_pkg::LM_ONE;
                                end
                                flash_pin_pkg::CMD_READ_STATUS_D: begin
                                    next_phase = flash_pin_pkg::PH_RD;
                                    next_mode  = flash_pin_pkg::LM_TWO;
                                end
                                flash_pin_pkg::CMD_READ_STATUS_Q: begin
                                    if (snap_qe) begin
                                        next_phase = flash_pin_pkg::PH_RD;
                                        next_mode  = flash_pin_pkg::LM_FOUR;
                                    end
                                end
                                flash_pin_pkg::CMD_WRITE_STATUS: begin
                                    next_phase = flash_pin_pkg::PH_WR1;
                                end
                                flash_pin_pkg::CMD_WRITE_STATUS_Q: begin
                                    if (snap_qe) begin
                                        next_phase = flash_pin_pkg::PH_WR4;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                flash_pin_pkg::PH_WR1: begin
                    next_sr  = {sr[6:0], data_lane_in[0]};
                    next_cnt = cnt + 3'h1;
                    if (cnt == flash_pin_pkg::LAST_SINGLE_BEAT) begin
                        next_wr_word = next_sr;
                        next_wr_tog  = !wr_tog;
                        next_phase   = flash_pin_pkg::PH_IGNORE;
                    end
                end
                flash_pin_pkg::PH_WR4: begin
                    next_sr  = {sr[3:0], data_lane_in};
                    next_cnt = cnt + 3'h1;
                    if (cnt == flash_pin_pkg::LAST_QUAD_BEAT) begin
                        next_wr_word = next_sr;
                        next_wr_tog  = !wr_tog;
                        next_phase   = flash_pin_pkg::PH_IGNORE;
                    end
                end
                flash_pin_pkg::PH_RD: begin
                end
                flash_pin_pkg::PH_IGNORE: begin
                end
                default: begin
                    next_phase = flash_pin_pkg::PH_IGNORE;
                end
            endcase
        end
    end

    // deselect holds the frame logic idle, which is the standby state
    always_ff @(posedge sck or posedge lif.clear) begin
        if (lif.clear) begin
            phase <= flash_pin_pkg::PH_CMD;
            mode  <= flash_pin_pkg::LM_NONE;
            cnt   <= 3'h0;
            sr    <= 8'h00;
        end else begin
            phase <= next_phase;
            mode  <= next_mode;
            cnt   <= next_cnt;
            sr    <= next_sr;
        end
    end

    // written word and its toggle survive deselect for the crossing
    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            wr_word <= 8'h00;
            wr_tog  <= 1'b0;
        end else begin
            wr_word <= next_wr_word;
            wr_tog  <= next_wr_tog;
        end
    end

    lane_out_stage u_stage (
        .sck (sck),
        .lif (lif)
    );
    assign data_lane_out = lif.out;
    assign data_lane_oe  = lif.oe;

    // ------------------------------------------------------------
    // crossings into the system clock
    // ------------------------------------------------------------
    bit_sync #(.W(3), .RESET_VAL(3'h7)) u_pin_sync (
        .clk   (clk_sys),
        .rst_b (rst_b),
        .d     ({chip_select_n, data_lane_in[3:2]}),
        .q     (pins_sync)
    );
    bit_sync #(.W(1), .RESET_VAL(1'b0)) u_tog_sync (
        .clk   (clk_sys),
        .rst_b (rst_b),
        .d     (wr_tog),
        .q     (tog_sync)
    );

    // ------------------------------------------------------------
    // status register and bus slave
    // ------------------------------------------------------------
    // write protect applies to bus writes and serial writes alike
    function automatic logic [7:0] guarded(input logic [7:0] cur,
                                           input logic [7:0] req,
                                           input logic       wp_n);
        logic locked;
        locked = cur[flash_pin_pkg::STATUS_WRITE_DISABLE_BIT] && !wp_n;
        // with write-disable clear the pin level does not matter
        guarded = locked ? cur : (req & flash_pin_pkg::STATUS_MASK);
    endfunction

    always_comb begin
        logic       wp_eff;
        logic       bus_wr;
        logic       spi_wr;
        logic       lock_now;
        logic [7:0] mid;
        wp_eff   = status[flash_pin_pkg::QE_BIT] || pins_sync[0];
        bus_wr   = avs_write && !avs_waitrequest;
        spi_wr   = tog_sync != prev_tog;
        lock_now = status[flash_pin_pkg::STATUS_WRITE_DISABLE_BIT] && !wp_eff;
        mid      = status;
        if (bus_wr && avs_address == flash_pin_pkg::ADDR_STATUS) begin
            mid = guarded(status, avs_writedata[7:0], wp_eff);
        end
        next_status = spi_wr ? guarded(mid, wr_word, wp_eff) : mid;
        next_rejects = rejects;
        if (lock_now && (spi_wr || (bus_wr && avs_address == flash_pin_pkg::ADDR_STATUS))) begin
            next_rejects = rejects + 16'h0001;
        end
        next_hrs = hrs;
        if (bus_wr && avs_address == flash_pin_pkg::ADDR_READ_PARAM) begin
            next_hrs = avs_writedata[0];
        end
        // power-up arming needs chip select seen high first
        next_armed = armed || pins_sync[2];
        next_snap  = pins_sync[2] ? {armed, hrs, status} : snap;
        next_restart_seen = restart_seen;
        if (bus_wr && avs_address == flash_pin_pkg::ADDR_STATE) begin
            next_restart_seen = 1'b0;
        end
        // a restart in the clearing cycle still sets the flag
        next_restart_seen = next_restart_seen ||
                            (!status[flash_pin_pkg::QE_BIT] && hrs && !pins_sync[1]);
        // one wait cycle, then a single-cycle accept
        next_wait  = !((avs_read || avs_write) && avs_waitrequest);
        next_rdata = 32'h0000_0000;
        unique case (avs_address)
            flash_pin_pkg::ADDR_STATUS:     next_rdata = {24'h000000, status};
            flash_pin_pkg::ADDR_READ_PARAM: next_rdata = {31'h00000000, hrs};
            flash_pin_pkg::ADDR_STATE:      next_rdata = {28'h0000000, restart_seen,
                                                          armed, pins_sync[2], !pins_sync[2]};
            flash_pin_pkg::ADDR_REJECTS:    next_rdata = {16'h0000, rejects};
            default:                        next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status          <= flash_pin_pkg::STATUS_RESET;
            hrs             <= flash_pin_pkg::HRS_RESET;
            armed           <= 1'b0;
            snap            <= 10'h000;
            prev_tog        <= 1'b0;
            rejects         <= 16'h0000;
            restart_seen    <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            standby         <= 1'b1;
        end else begin
            status          <= next_status;
            hrs             <= next_hrs;
            armed           <= next_armed;
            snap            <= next_snap;
            prev_tog        <= tog_sync;
            rejects         <= next_rejects;
            restart_seen    <= next_restart_seen;
            avs_waitrequest <= next_wait;
            avs_readdata    <= next_rdata;
            standby         <= pins_sync[2];
        end
    end
endmodule
`default_nettype wire

//--- src/flash_pin_pkg.sv
// shared constants and types for the serial flash pin interface
package flash_pin_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the register bus)
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_STATUS     = 4'h0;
    localparam logic [3:0]  ADDR_READ_PARAM = 4'h4;
    localparam logic [3:0]  ADDR_STATE      = 4'h8;
    localparam logic [3:0]  ADDR_REJECTS    = 4'hC;

    // ------------------------------------------------------------
    // status byte layout
    // ------------------------------------------------------------
    localparam int          STATUS_WRITE_DISABLE_BIT        = 7;
    localparam int          QE_BIT          = 6;
    localparam logic [7:0]  STATUS_MASK     = 8'hFC;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic        HRS_RESET       = 1'h0;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_WRITE_STATUS   = 8'h01;
    localparam logic [7:0]  CMD_WRITE_STATUS_Q = 8'h32;
    localparam logic [7:0]  CMD_READ_STATUS    = 8'h05;
    localparam logic [7:0]  CMD_READ_STATUS_D  = 8'h3B;
    localparam logic [7:0]  CMD_READ_STATUS_Q  = 8'h6B;

    // ------------------------------------------------------------
    // beat counts
    // ------------------------------------------------------------
    localparam logic [2:0]  LAST_SINGLE_BEAT = 3'h7;
    localparam logic [2:0]  LAST_QUAD_BEAT   = 3'h1;

    typedef enum logic [1:0] {
        LM_NONE = 2'b00,
        LM_ONE  = 2'b01,
        LM_TWO  = 2'b10,
        LM_FOUR = 2'b11
    } lane_mode_t;

    typedef enum logic [2:0] {
        PH_CMD    = 3'b000,
        PH_WR1    = 3'b001,
        PH_WR4    = 3'b010,
        PH_RD     = 3'b011,
        PH_IGNORE = 3'b100
    } phase_t;

endpackage

//--- src/lane_if.sv
// carrier between the frame engine and the falling-edge output stage
`timescale 1ns/1ps
`default_nettype none
interface lane_if;
    logic                      clear;
    logic                      paused;
    flash_pin_pkg::lane_mode_t rd_mode;
    logic [7:0]                rd_byte;
    logic [3:0]                out;
    logic [3:0]                oe;

    modport engine (output clear, paused, rd_mode, rd_byte, input out, oe);
    modport stage  (input clear, paused, rd_mode, rd_byte, output out, oe);
endinterface
`default_nettype wire

//--- src/bit_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int         W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

//--- src/lane_out_stage.sv
// falling-edge output stage driving the data lanes and their enables
`timescale 1ns/1ps
`default_nettype none
module lane_out_stage (
    // link clock
    input  wire logic sck,
    // engine side
    lane_if.stage     lif
);
    logic [2:0] idx;
    logic [2:0] next_idx;
    logic [3:0] next_out;
    logic [3:0] next_oe;
    logic [7:0] sh;

    // pick the next slice of the byte; lanes let go whenever not sending
    always_comb begin
        sh       = lif.rd_byte << idx;
        next_idx = idx;
        next_out = 4'h0;
        next_oe  = 4'h0;
        if (!lif.paused) begin
            unique case (lif.rd_mode)
                flash_pin_pkg::LM_NONE: begin
                end
                flash_pin_pkg::LM_ONE: begin
                    next_out = {2'b00, sh[7], 1'b0};
                    next_oe  = 4'h2;
                    next_idx = idx + 3'h1;
                end
                flash_pin_pkg::LM_TWO: begin
                    next_out = {2'b00, sh[7:6]};
                    next_oe  = 4'h3;
                    next_idx = idx + 3'h2;
                end
                flash_pin_pkg::LM_FOUR: begin
                    next_out = sh[7:4];
                    next_oe  = 4'hF;
                    next_idx = idx + 3'h4;
                end
            endcase
        end
    end

    // outputs change on falling edges; deselect floats every lane at once
    always_ff @(negedge sck or posedge lif.clear) begin
        if (lif.clear) begin
            idx     <= 3'h0;
            lif.out <= 4'h0;
            lif.oe  <= 4'h0;
        end else begin
            idx     <= next_idx;
            lif.out <= next_out;
            lif.oe  <= next_oe;
        end
    end
endmodule
`default_nettype wire

//--- bench/flash_pin_properties.sv
// concurrent checks on the pins of the serial flash pin interface
`timescale 1ns/1ps
`default_nettype none
module flash_pin_properties (
    // clocks and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        sck,
    // register bus
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // serial link
    input wire logic        chip_select_n,
    input wire logic [3:0]  data_lane_oe,
    input wire logic        standby
);
    // ----------------------------------------
    // bus steps
    // ----------------------------------------
    sequence req_pending;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence read_done;
        avs_read && !avs_waitrequest;
    endsequence
    answer_one_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        req_pending |=> !avs_waitrequest) else $error("bus answer late");
    wait_single_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
    unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        read_done ##0 (avs_address[1:0] != 2'h0) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    status_layout_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        read_done ##0 (avs_address == flash_pin_pkg::ADDR_STATUS)
        |-> avs_readdata[31:8] == 24'h0 && avs_readdata[1:0] == 2'h0)
        else $error("status spare bits set");
    state_standby_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        standby [*3] ##0 read_done ##0 (avs_address == flash_pin_pkg::ADDR_STATE)
        |-> avs_readdata[1]) else $error("state misses standby");
    // select and lanes
    deselect_float_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        chip_select_n && $past(chip_select_n) |-> data_lane_oe == 4'h0)
        else $error("lane driven while deselected");
    standby_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        chip_select_n [*4] |-> standby) else $error("no standby");
    standby_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !chip_select_n [*4] |-> !standby) else $error("standby while selected");
    lane_legal_a: assert property (@(posedge sck) disable iff (chip_select_n)
        data_lane_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("bad enable set");
endmodule
bind serial_flash_pin_interface flash_pin_properties chk_u (.*);
`default_nettype wire

//--- bench/spi_master_model.sv
// behavioural spi master standing on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    // link pins
    output logic            sck,
    output logic            chip_select_n,
    output var logic [3:0]  data_lane_in,
    // device side and pins
    input  wire logic [3:0] data_lane_out,
    input  wire logic [3:0] data_lane_oe,
    input  wire logic       wp_n,
    input  wire logic       hold_n,
    input  wire logic       cpol
);
    logic       mosi;
    logic [3:0] rel;
    logic [3:0] pins;
    assign pins = {hold_n, wp_n, 1'b1, mosi};
    // released lanes read high (pull-ups)
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            data_lane_in[i] = data_lane_oe[i] ? data_lane_out[i] : rel[i] ? 1'b1 : pins[i];
        end
    end
    initial begin
        sck = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b1;
        rel = 4'h0;
    end
    // one bit: set while low, taken at the rise
    task automatic shift_out(input logic b);
        sck = 1'b0;
        mosi = b;
        #62.5;
        sck = 1'b1;
        #62.5;
    endtask
    // lanes: 0 write, 1/2/4 read width, 9 clocks a write with no select
    task automatic frame(input logic [7:0] cmd, input logic [7:0] wr, input int lanes,
                         output logic [7:0] rd);
        rd = 8'h00;
        sck = cpol;
        #62.5;
        chip_select_n = (lanes == 9);
        #62.5;
        for (int i = 7; i >= 0; i--) shift_out(cmd[i]);
        for (int i = 7; i >= 0; i--) if (lanes == 0 || lanes == 9) shift_out(wr[i]);
        rel = (lanes == 1) ? 4'h2 : (lanes == 2) ? 4'h3 : 4'hF;
        if (lanes inside {1, 2, 4}) begin
            for (int b = 0; b < 8 / lanes; b++) begin
                sck = 1'b0;
                #62.5;
                rd = (lanes == 1) ? {rd[6:0], data_lane_in[1]} :
                     (lanes == 2) ? {rd[5:0], data_lane_in[1:0]} : {rd[3:0], data_lane_in};
                sck = 1'b1;
                #62.5;
            end
        end
        sck = cpol;
        #62.5;
        chip_select_n = 1'b1;
        rel = 4'h0;
        mosi = 1'b1;
        #500;
    endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the serial flash pin interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_sys;
    logic        rst_b;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sck;
    logic        chip_select_n;
    logic [3:0]  data_lane_in;
    logic [3:0]  data_lane_out;
    logic [3:0]  data_lane_oe;
    logic        standby;
    logic        wp_n;
    logic        hold_n;
    logic        cpol;
    int          err_total;
    int          check_count;
    logic [7:0]  exp_st;
    logic [7:0]  rd;
    logic [31:0] d;
    logic [7:0]  val_tab [7] = '{8'h80, 8'h3C, 8'h3C, 8'hC4, 8'h08, 8'h80, 8'h00};
    logic [6:0]  wp_tab = 7'b0000101;
    serial_flash_pin_interface dut_u (.*);
    spi_master_model m_u (.*);
    // write dropped when locked, pin low, lane 2 not a lane
    function automatic logic [7:0] prot(input logic [7:0] old, nv, input logic wp);
        return (old[flash_pin_pkg::STATUS_WRITE_DISABLE_BIT] && !wp && !old[flash_pin_pkg::QE_BIT]) ?
               old : nv & flash_pin_pkg::STATUS_MASK;
    endfunction
    task automatic check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one access, held until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        int n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            err_total++;
            report_and_stop();
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // a hang counts as a mismatch
    initial begin
        #5000000;
        err_total++;
        report_and_stop();
    end
    initial begin
        {rst_b, avs_address, avs_read, avs_write, avs_writedata} = '0;
        {cpol, err_total, check_count} = '0;
        {wp_n, hold_n} = 2'h3;
        d = $urandom(15);
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check("standby", 32'(standby), 32'h1);
        check("idle oe", 32'(data_lane_oe), 32'h0);
        bus(0, flash_pin_pkg::ADDR_STATUS, 0, d);
        check("status reset", d, 32'(flash_pin_pkg::STATUS_RESET));
        bus(0, 4'h2, 0, d);
        check("unmapped", d, 32'h0);
        bus(0, flash_pin_pkg::ADDR_STATE, 0, d);
        check("state standby", 32'(d[1]), 32'h1);
        $display("test reset done");
        // serial write then reads at every width, both clock modes
        for (int k = 0; k < 4; k++) begin
            cpol = k[0];
            exp_st = (k == 0) ? 8'hFC : 8'($urandom) & flash_pin_pkg::STATUS_MASK;
            m_u.frame(flash_pin_pkg::CMD_WRITE_STATUS, exp_st, 0, rd);
            bus(0, flash_pin_pkg::ADDR_STATUS, 0, d);
            check("serial write", d, 32'(exp_st));
            m_u.frame(flash_pin_pkg::CMD_READ_STATUS, 0, 1, rd);
            check("single read", 32'(rd), 32'(exp_st));
            m_u.frame(flash_pin_pkg::CMD_READ_STATUS_D, 0, 2, rd);
            check("dual read", 32'(rd), 32'(exp_st));
            m_u.frame(flash_pin_pkg::CMD_READ_STATUS_Q, 0, 4, rd);
            check("quad read", 32'(rd), 32'(exp_st[6] ? exp_st : 8'hFF));
            $display("test serial round %0d done", k);
        end
        // protect pin vs write-disable and quad bits
        for (int r = 0; r < 7; r++) begin
            @(posedge clk_sys) wp_n <= wp_tab[r];
            repeat (4) @(posedge clk_sys);
            exp_st = prot(exp_st, val_tab[r], wp_tab[r]);
            bus(1, flash_pin_pkg::ADDR_STATUS, 32'(val_tab[r]), d);
            bus(0, flash_pin_pkg::ADDR_STATUS, 0, d);
            check("protect", d, 32'(exp_st));
        end
        bus(0, flash_pin_pkg::ADDR_REJECTS, 0, d);
        check("rejects", d, 32'h2);
        $display("test protect done");
        @(posedge clk_sys) wp_n <= 1'b1;
        // lane 3 low mid-read: pause, then restart
        for (int h = 0; h < 2; h++) begin
            bus(1, flash_pin_pkg::ADDR_READ_PARAM, 32'(h), d);
            fork
                m_u.frame(flash_pin_pkg::CMD_READ_STATUS, 0, 1, rd);
                begin
                    #1600 @(posedge clk_sys) hold_n <= 1'b0;
                    repeat (3) @(posedge clk_sys);
                    check("held oe", 32'(data_lane_oe), 32'h0);
                    hold_n <= 1'b1;
                end
            join
            bus(0, flash_pin_pkg::ADDR_STATE, 0, d);
            check("restart seen", 32'(d[3]), 32'(h));
            bus(1, flash_pin_pkg::ADDR_STATE, 0, d);
        end
        $display("test pause done");
        m_u.frame(flash_pin_pkg::CMD_WRITE_STATUS, 8'h3C, 9, rd);
        bus(0, flash_pin_pkg::ADDR_STATUS, 0, d);
        check("unselected write", d, 32'(exp_st));
        $display("test unselected done");
        report_and_stop();
    end
endmodule
`default_nettype wire
